// ===== rtl/gpio_consts.svh
// constants of the dual-byte gpio block: offsets, fields, reset values, timing
`ifndef GPIO_CONSTS_SVH
`define GPIO_CONSTS_SVH

// ****************************************
// register indices (byte address = 4 * index, low 10 bits decoded)
// ****************************************
`define IDX_W 10
`define IDX_RISE_B 32'h0FFFF0C8
`define IDX_FALL_B 32'h0FFFF0CA
`define IDX_PORT_C 32'hFFFFF01C
`define IDX_DIR_A 32'hFFFFF038
`define IDX_DIR_B 32'hFFFFF03A
`define IDX_DRV_A 32'hFFFFF0B6
`define IDX_DATA_A 32'hFFFFF018
`define IDX_DATA_B 32'hFFFFF01A
`define IDX_IRQ_STS 32'hFFFFF100
`define IDX_IRQ_MSK 32'hFFFFF101

// ****************************************
// field masks and reset values
// ****************************************
`define DRV_A_MASK 8'h06
`define EDGE_MASK 6'h3F
`define RST_DIR 8'hFF
`define RST_LATCH 8'h00
`define RST_DRV 8'h00
`define RST_EDGE 6'h00
`define RST_PORT_C 8'h00
`define RST_MSK 6'h00

// ****************************************
// noise filter timing
// ****************************************
`define FILT_TIME_NS 30
`define CLK_PERIOD_NS 10
`define FILT_CYCLES ((`FILT_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ===== rtl/gpio_pkg.sv
// types shared by the dual-byte gpio block
package gpio_pkg;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe_n;
  } pin_drive_s;

  typedef struct packed {
    logic [7:0] dir_a;
    logic [7:0] dir_b;
    logic [7:0] lat_a;
    logic [7:0] lat_b;
    logic [7:0] lat_c;
    logic [7:0] drv_a;
    logic [5:0] rise_b;
    logic [5:0] fall_b;
    logic [5:0] sts;
    logic [5:0] msk;
    logic [7:0] meta_a;
    logic [7:0] sync_a;
    logic [7:0] meta_b;
    logic [7:0] sync_b;
    logic [9:0] filt;
    logic [9:0][1:0] fcnt;
    logic [5:0] edge_req;
    pin_drive_s pa;
    pin_drive_s pb;
    logic irq;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } gpio_state_s;

endpackage

// ===== rtl/gpio_ports.sv
// dual-byte gpio with third output port, edge qualifiers and apb slave
//
// Behaviour
// - port pins individually output (direction 0) or input (direction 1)
// - input-mode read returns pin level; write updates latch only, pin undriven
// - output-mode read returns latch; written value drives pin at once
// - serial out/clock pins select push-pull or open-drain; drive bits 1,2 only
// - upper four first-port pins filtered before reaching the timers
// - pin driven with latch ORed with alternate-function output
// - reset puts every pin of both ports in input mode
// - direction, drive and edge registers writable bitwise or as a byte; the code writes whole bytes only
// - first port shared with serial, clock out and timer functions; no pull-ups
// - lower six second-port pins filtered; top two carry timer outputs
// - rising edge with its enable set raises a request
// - falling edge with its enable set raises a request
// - reset clears both edge enable registers
// - third port output latch, reset zero, drives its pins
// - edge enables only qualify requests to capture and timer logic; the code also sets interrupt status from them
//
// The implementer's own choice: the APB slave port.
`include "gpio_consts.svh"
`timescale 1ns/100ps
`default_nettype none

module gpio_ports
  import gpio_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] pa_in,
  input wire logic [7:0] alt_a,
  output pin_drive_s pa_drive,
  input wire logic [7:0] pb_in,
  input wire logic [7:0] alt_b,
  output pin_drive_s pb_drive,
  output logic [7:0] pc_out,
  output logic [3:0] timer_in_a,
  output logic [5:0] capture_b,
  output logic [5:0] edge_req,
  output logic irq
);

  gpio_state_s r_reg;
  gpio_state_s r_next;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic hit(input logic [11:0] a, input logic [31:0] idx);
    hit = (a[11:2] == idx[`IDX_W-1:0]);
  endfunction

  // input bits read the pin, output bits read the latch
  function automatic logic [7:0] mix_read(input logic [7:0] dir, input logic [7:0] pin,
                                          input logic [7:0] lat);
    mix_read = (dir & pin) | (~dir & lat);
  endfunction

  // open-drain bits only pull low; push-pull drives both levels
  function automatic pin_drive_s drive(input logic [7:0] dir, input logic [7:0] val,
                                       input logic [7:0] od);
    pin_drive_s d;
    d.out = val & ~od;
    d.oe_n = dir | (od & val);
    drive = d;
  endfunction

  // ****************************************
  // next state
  // ****************************************
  logic setup;
  logic wr;
  logic mapped;
  logic [31:0] rd;
  logic [9:0] raw;
  logic [5:0] rise;
  logic [5:0] fall;
  logic [5:0] ev;
  logic [5:0] clr;

  always_comb begin
    r_next = r_reg;
    setup = psel & ~penable;
    wr = psel & penable & pwrite & r_reg.pready & pstrb[0];
    clr = 6'h00;
    rd = 32'h0000_0000;
    mapped = 1'b1;

    // two-flop synchronisers on the pin inputs
    r_next.meta_a = pa_in;
    r_next.sync_a = r_reg.meta_a;
    r_next.meta_b = pb_in;
    r_next.sync_b = r_reg.meta_b;

    // a level is accepted only after it stood FILT_CYCLES samples
    raw = {r_reg.sync_b[5:0], r_reg.sync_a[7:4]};
    for (int i = 0; i < 10; i++) begin
      if (raw[i] == r_reg.filt[i]) begin
        r_next.fcnt[i] = 2'h0;
      end else if (r_reg.fcnt[i] == 2'((`FILT_CYCLES) - 1)) begin
        r_next.filt[i] = raw[i];
        r_next.fcnt[i] = 2'h0;
      end else begin
        r_next.fcnt[i] = r_reg.fcnt[i] + 2'h1;
      end
    end

    // qualified edges are requests to capture and timer logic
    rise = r_next.filt[9:4] & ~r_reg.filt[9:4];
    fall = ~r_next.filt[9:4] & r_reg.filt[9:4];
    ev = (rise & r_reg.rise_b) | (fall & r_reg.fall_b);
    r_next.edge_req = ev;

    // register read decode
    if (hit(paddr, `IDX_DATA_A)) begin
      rd[7:0] = mix_read(r_reg.dir_a, r_reg.sync_a, r_reg.lat_a);
    end else if (hit(paddr, `IDX_DATA_B)) begin
      rd[7:0] = mix_read(r_reg.dir_b, r_reg.sync_b, r_reg.lat_b);
    end else if (hit(paddr, `IDX_PORT_C)) begin
      rd[7:0] = r_reg.lat_c;
    end else if (hit(paddr, `IDX_DIR_A)) begin
      rd[7:0] = r_reg.dir_a;
    end else if (hit(paddr, `IDX_DIR_B)) begin
      rd[7:0] = r_reg.dir_b;
    end else if (hit(paddr, `IDX_DRV_A)) begin
      rd[7:0] = r_reg.drv_a;
    end else if (hit(paddr, `IDX_RISE_B)) begin
      rd[5:0] = r_reg.rise_b;
    end else if (hit(paddr, `IDX_FALL_B)) begin
      rd[5:0] = r_reg.fall_b;
    end else if (hit(paddr, `IDX_IRQ_STS)) begin
      rd[5:0] = r_reg.sts;
    end else if (hit(paddr, `IDX_IRQ_MSK)) begin
      rd[5:0] = r_reg.msk;
    end else begin
      mapped = 1'b0;
    end

    // zero-wait slave: ready in the first access cycle
    r_next.pready = setup;
    r_next.pslverr = setup & ~mapped;
    if (setup && !pwrite) begin
      r_next.prdata = rd;
    end

    // whole-byte writes; single-bit updates are read-modify-write by software
    if (wr && mapped) begin
      if (hit(paddr, `IDX_DATA_A)) begin
        r_next.lat_a = pwdata[7:0];
      end
      if (hit(paddr, `IDX_DATA_B)) begin
        r_next.lat_b = pwdata[7:0];
      end
      if (hit(paddr, `IDX_PORT_C)) begin
        r_next.lat_c = pwdata[7:0];
      end
      if (hit(paddr, `IDX_DIR_A)) begin
        r_next.dir_a = pwdata[7:0];
      end
      if (hit(paddr, `IDX_DIR_B)) begin
        r_next.dir_b = pwdata[7:0];
      end
      if (hit(paddr, `IDX_DRV_A)) begin
        r_next.drv_a = pwdata[7:0] & `DRV_A_MASK;
      end
      if (hit(paddr, `IDX_RISE_B)) begin
        r_next.rise_b = pwdata[5:0] & `EDGE_MASK;
      end
      if (hit(paddr, `IDX_FALL_B)) begin
        r_next.fall_b = pwdata[5:0] & `EDGE_MASK;
      end
      if (hit(paddr, `IDX_IRQ_STS)) begin
        clr = pwdata[5:0];
      end
      if (hit(paddr, `IDX_IRQ_MSK)) begin
        r_next.msk = pwdata[5:0];
      end
    end

    // a new event outranks a clear in the same cycle
    r_next.sts = (r_reg.sts & ~clr) | ev;
    r_next.irq = |(r_next.sts & r_next.msk);

    // pins follow the new latch at the write edge; alternate outputs ORed in.
    // no pull-ups exist, so an undriven input pin floats.
    r_next.pa = drive(r_next.dir_a, r_next.lat_a | alt_a, r_next.drv_a);
    r_next.pb = drive(r_next.dir_b, r_next.lat_b | alt_b, 8'h00);
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg <= '0;
      r_reg.dir_a <= `RST_DIR;
      r_reg.dir_b <= `RST_DIR;
      r_reg.lat_a <= `RST_LATCH;
      r_reg.lat_b <= `RST_LATCH;
      r_reg.lat_c <= `RST_PORT_C;
      r_reg.drv_a <= `RST_DRV;
      r_reg.rise_b <= `RST_EDGE;
      r_reg.fall_b <= `RST_EDGE;
      r_reg.msk <= `RST_MSK;
      r_reg.pa.oe_n <= 8'hFF;
      r_reg.pb.oe_n <= 8'hFF;
    end else begin
      r_reg <= r_next;
    end
  end

  assign prdata = r_reg.prdata;
  assign pready = r_reg.pready;
  assign pslverr = r_reg.pslverr;
  assign pa_drive = r_reg.pa;
  assign pb_drive = r_reg.pb;
  assign pc_out = r_reg.lat_c;
  assign timer_in_a = r_reg.filt[3:0];
  assign capture_b = r_reg.filt[9:4];
  assign edge_req = r_reg.edge_req;
  assign irq = r_reg.irq;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic wr_a;
  assign wr_a = wr && hit(paddr, `IDX_DATA_A);

  chk_input_float: assert property (
    r_reg.dir_a[3] |-> pa_drive.oe_n[3])
    else $error("input-mode pin is driven");
  chk_input_read: assert property (
    setup && !pwrite && hit(paddr, `IDX_DATA_A) && r_reg.dir_a == 8'hFF
    |=> prdata[7:0] == $past(r_reg.sync_a))
    else $error("input-mode read did not return pin level");
  chk_output_drive: assert property (
    wr_a && r_reg.dir_a == 8'h00 && r_reg.drv_a == 8'h00
    |=> pa_drive.out == $past(pwdata[7:0] | alt_a) && pa_drive.oe_n == 8'h00)
    else $error("written value not driven on output pin");
  chk_open_drain: assert property (
    r_reg.drv_a[1] && !r_reg.dir_a[1] |-> !pa_drive.out[1] &&
    (pa_drive.oe_n[1] == (r_reg.lat_a[1] | $past(alt_a[1]))))
    else $error("open-drain pin drove high");
  // port b has no open-drain option, so an output bit always drives
  chk_b_push_pull: assert property (
    !r_reg.dir_b[1] |-> !pb_drive.oe_n[1])
    else $error("second-port output pin released");
  chk_b_float: assert property (
    r_reg.dir_b[0] |-> pb_drive.oe_n[0])
    else $error("second-port input pin is driven");
  chk_drive_bits: assert property (
    (r_reg.drv_a & ~`DRV_A_MASK) == 8'h00)
    else $error("reserved drive-type bit set");
  chk_alt_or: assert property (
    !r_reg.dir_b[7] |-> pb_drive.out[7] == (r_reg.lat_b[7] | $past(alt_b[7])))
    else $error("pin is not latch ORed with alternate output");
  chk_filter_hold: assert property (
    $changed(r_reg.filt[0]) |-> $past(r_reg.sync_a[4], 1) == r_reg.filt[0] &&
    $past(r_reg.sync_a[4], 2) == r_reg.filt[0] && $past(r_reg.sync_a[4], 3) == r_reg.filt[0])
    else $error("filter passed a level held under three samples");
  chk_edge_rise: assert property (
    $rose(r_reg.filt[4]) && $past(r_reg.rise_b[0]) |-> edge_req[0])
    else $error("enabled rising edge gave no request");
  chk_edge_fall: assert property (
    $fell(r_reg.filt[9]) && $past(r_reg.fall_b[5]) |-> edge_req[5])
    else $error("enabled falling edge gave no request");
  chk_edge_none: assert property (
    !$past(r_reg.rise_b[2]) && !$past(r_reg.fall_b[2]) |-> !edge_req[2])
    else $error("request without an enabled edge");
  chk_port_c: assert property (
    wr && hit(paddr, `IDX_PORT_C) |=> pc_out == $past(pwdata[7:0]))
    else $error("third port latch not written");
  chk_port_c_hold: assert property (
    !(wr && hit(paddr, `IDX_PORT_C)) |=> $stable(pc_out))
    else $error("third port latch changed without a write");
  // status is set in the very cycle the request pulses
  chk_req_status: assert property (
    edge_req[1] |-> r_reg.sts[1])
    else $error("request did not set its status bit");

  cov_write_a: cover property (wr_a ##1 pready);
  cov_edge: cover property (|edge_req);
  cov_irq: cover property ($rose(irq));
  cov_unmapped: cover property (pslverr);
  cov_open_drain: cover property (r_reg.drv_a[2] && !r_reg.dir_a[2] && pa_drive.oe_n[2]);

endmodule

`default_nettype wire

// ===== testbench/pin_partner.sv
// pin-side model: resolves every first- and second-port pin from the block's drive and the outside world
`timescale 1ns/100ps
`default_nettype none
module pin_partner
  import gpio_pkg::*;
(
  input wire pin_drive_s pa_drive,
  input wire pin_drive_s pb_drive,
  input wire logic [7:0] ext_a,
  input wire logic [7:0] ext_b,
  output logic [7:0] pa_in,
  output logic [7:0] pb_in
);
  // no pull-ups: a released pin shows only what the outside drives
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pa_in[i] = pa_drive.oe_n[i] ? ext_a[i] : pa_drive.out[i];
      pb_in[i] = pb_drive.oe_n[i] ? ext_b[i] : pb_drive.out[i];
    end
  end
endmodule
`default_nettype wire

// ===== testbench/dual_byte_gpio_with_edge_select_tb_top.sv
// self-checking bench for the dual-byte gpio block
`include "gpio_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module dual_byte_gpio_with_edge_select_tb_top
  import gpio_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb, timer_in_a;
  logic [7:0] pa_in, pb_in, alt_a, alt_b, ext_a, ext_b, pc_out, d, l;
  logic [5:0] capture_b, edge_req;
  pin_drive_s pa_drive, pb_drive;
  int error_cnt, num_checks, edge_cnt, sel_bit, c0;

  gpio_ports uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pa_in(pa_in), .alt_a(alt_a), .pa_drive(pa_drive),
    .pb_in(pb_in), .alt_b(alt_b), .pb_drive(pb_drive), .pc_out(pc_out),
    .timer_in_a(timer_in_a), .capture_b(capture_b), .edge_req(edge_req), .irq(irq));
  pin_partner pins (.pa_drive(pa_drive), .pb_drive(pb_drive), .ext_a(ext_a), .ext_b(ext_b),
    .pa_in(pa_in), .pb_in(pb_in));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    if (edge_req[sel_bit] === 1'b1) edge_cnt <= edge_cnt + 1;
  end

  // ****************************************
  // tasks
  // ****************************************
  task automatic report_and_stop;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [31:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx[9:0], 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      error_cnt++;
      $display("[ERR] %0t no bus answer", $time);
      report_and_stop();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [31:0] idx, input logic [31:0] v);
    apb(1'b1, idx, v);
  endtask

  task automatic rdchk(input logic [31:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    chk(rd, exp);
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    pstrb = 4'hF;
    {alt_a, alt_b, ext_a, ext_b} = '0;
    {error_cnt, num_checks, edge_cnt, sel_bit} = '0;
    presetn = 1'b0;
    void'($urandom(79));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({24'h0, pa_drive.oe_n & pb_drive.oe_n}, 32'h000000FF);
    rdchk(`IDX_DIR_A, 32'h000000FF);
    rdchk(`IDX_DIR_B, 32'h000000FF);
    rdchk(`IDX_DRV_A, 32'h0);
    rdchk(`IDX_RISE_B, 32'h0);
    rdchk(`IDX_FALL_B, 32'h0);
    rdchk(`IDX_PORT_C, 32'h0);
    rdchk(32'h00000200, 32'h0);
    chk({31'h0, err}, 32'h1);
    for (int k = 0; k < 8; k++) begin
      d = 8'($urandom);
      wr(`IDX_DRV_A, {24'h0, d});
      rdchk(`IDX_DRV_A, {24'h0, d & `DRV_A_MASK});
      wr(`IDX_PORT_C, {24'h0, ~d});
      @(posedge pclk);
      chk({24'h0, pc_out}, {24'h0, ~d});
      wr(`IDX_RISE_B, {24'h0, d});
      rdchk(`IDX_RISE_B, {24'h0, d & 8'h3F});
    end
    wr(`IDX_DRV_A, 32'h0);
    // random directions: output bits read the latch, input bits the pin
    for (int k = 0; k < 10; k++) begin
      d = 8'($urandom);
      l = 8'($urandom);
      ext_a <= 8'($urandom);
      alt_a <= 8'($urandom);
      alt_b <= 8'($urandom);
      wr(`IDX_DIR_A, {24'h0, d});
      wr(`IDX_DATA_A, {24'h0, l});
      wr(`IDX_DIR_B, {24'h0, ~d});
      wr(`IDX_DATA_B, {24'h0, l});
      repeat (3) @(posedge pclk);
      chk({24'h0, pa_drive.oe_n}, {24'h0, d});
      chk({24'h0, pa_drive.out}, {24'h0, l | alt_a});
      chk({24'h0, pb_drive.out}, {24'h0, l | alt_b});
      rdchk(`IDX_DATA_A, {24'h0, (d & ext_a) | (~d & l)});
      rdchk(`IDX_DATA_B, {24'h0, (~d & ext_b) | (d & l)});
    end
    {alt_a, alt_b} <= '0;
    // alternate output used the proper way: latch and direction cleared first
    wr(`IDX_DIR_A, 32'h0);
    wr(`IDX_DATA_A, 32'h0);
    alt_a <= 8'hA5;
    repeat (3) @(posedge pclk);
    chk({24'h0, pa_drive.out}, 32'h000000A5);
    alt_a <= '0;
    wr(`IDX_DIR_A, 32'h0);
    wr(`IDX_DRV_A, 32'h000000FF);
    for (int k = 0; k < 4; k++) begin
      l = 8'(k << 1);
      wr(`IDX_DATA_A, {24'h0, l});
      repeat (2) @(posedge pclk);
      chk({24'h0, pa_drive.oe_n}, {24'h0, l & 8'h06});
      chk({24'h0, pa_drive.out}, {24'h0, l & 8'hF9});
    end
    wr(`IDX_DRV_A, 32'h0);
    wr(`IDX_DIR_A, 32'h000000FF);
    wr(`IDX_DIR_B, 32'h000000FF);
    for (int k = 0; k < 4; k++) begin
      ext_a <= 8'($urandom);
      repeat (8) @(posedge pclk);
      chk({28'h0, timer_in_a}, {28'h0, ext_a[7:4]});
      rdchk(`IDX_DATA_A, {24'h0, ext_a});
    end
    // every edge mode on each of the six filtered second-port inputs, interrupt unmasked
    wr(`IDX_IRQ_MSK, 32'h0000003F);
    for (int b = 0; b < 6; b++) begin
      for (int m = 0; m < 4; m++) begin
        sel_bit = b;
        wr(`IDX_RISE_B, {31'h0, m[0]} << b);
        wr(`IDX_FALL_B, {31'h0, m[1]} << b);
        wr(`IDX_IRQ_STS, 32'h0000003F);
        c0 = edge_cnt;
        ext_b[b] <= 1'b1;
        repeat (10) @(posedge pclk);
        chk({31'h0, capture_b[b]}, 32'h1);
        ext_b[b] <= 1'b0;
        repeat (10) @(posedge pclk);
        chk(32'(edge_cnt - c0), 32'(m[0]) + 32'(m[1]));
        chk({31'h0, irq}, {31'h0, m != 0});
        wr(`IDX_IRQ_STS, 32'h0000003F);
        @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
      end
    end
    // a two-cycle glitch is filtered out, then a masked edge still requests but raises no interrupt
    sel_bit = 0;
    wr(`IDX_RISE_B, 32'h0000003F);
    c0 = edge_cnt;
    ext_b[0] <= 1'b1;
    repeat (2) @(posedge pclk);
    ext_b[0] <= 1'b0;
    repeat (10) @(posedge pclk);
    chk(32'(edge_cnt - c0), 32'h0);
    wr(`IDX_IRQ_MSK, 32'h0);
    ext_b[0] <= 1'b1;
    repeat (10) @(posedge pclk);
    chk(32'(edge_cnt - c0), 32'h1);
    chk({31'h0, irq}, 32'h0);
    report_and_stop();
  end
endmodule
`default_nettype wire
